/* srb_cfg.svh */
// Offsets, reset values and timing figures of the ramp, status and brake block.
// Assumes inclusion by bare name from the block's design files.
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH

// Register indices; byte address is four times the index
`define SRB_IDX_CTRL 10'h100
`define SRB_IDX_STATUS 10'h101
`define SRB_IDX_IRQ_STAT 10'h102
`define SRB_IDX_IRQ_MASK 10'h103
`define SRB_IDX_SPD_CMD 10'h104
`define SRB_IDX_TRQ_CMD 10'h105
`define SRB_IDX_RSVD_A 10'h121
`define SRB_IDX_ACCEL 10'h122
`define SRB_IDX_DECEL 10'h123
`define SRB_IDX_SCURVE 10'h124
`define SRB_IDX_INERTIA 10'h125
`define SRB_IDX_ZERO_WIN 10'h126
`define SRB_IDX_TARGET 10'h127
`define SRB_IDX_SPD_FS 10'h128
`define SRB_IDX_TRQ_FS 10'h129
`define SRB_IDX_ON_DLY 10'h12A
`define SRB_IDX_OFF_DLY 10'h12B

// Control register fields
`define SRB_CTRL_W 4
`define SRB_CTRL_RST 4'h0
// Interrupt bits: zero speed rose, at speed rose, brake output changed, drive disabled
`define SRB_IRQ_W 4

// Reset values of the settings
`define SRB_ACCEL_RST 16'h00C8
`define SRB_DECEL_RST 16'h00C8
`define SRB_SCURVE_RST 16'h0000
`define SRB_INERTIA_RST 16'h000A
`define SRB_ZERO_WIN_RST 16'h000A
`define SRB_TARGET_RST 16'h0BB8
`define SRB_TRQ_FS_RST 16'h0064
`define SRB_ON_DLY_RST 16'h0000
`define SRB_OFF_DLY_RST 16'h0064

// Timing: the clock and the millisecond tick
`define SRB_CLK_MHZ 100
`define SRB_TICK_US 1000
// Analog input full scale in millivolts
`define SRB_FULL_MV 10000

`endif

/* srb_pkg.sv */
// Types shared by the ramp, status and brake block.
// Assumes nothing beyond a SystemVerilog compiler.
package srb_pkg;

  typedef enum logic [1:0] {
    SRB_MODE_POS = 2'h0,
    SRB_MODE_SPD = 2'h1,
    SRB_MODE_TRQ = 2'h2
  } srb_mode_t;

  typedef enum logic [3:0] {
    SRB_ST_OFF = 4'h1,
    SRB_ST_ONDLY = 4'h2,
    SRB_ST_RUN = 4'h4,
    SRB_ST_OFFDLY = 4'h8
  } srb_state_t;

  typedef struct packed {
    logic stop_coast;
    srb_mode_t mode;
    logic servo_on;
  } srb_ctrl_t;

  typedef struct packed {
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] scurve;
    logic [15:0] inertia;
    logic [15:0] zero_win;
    logic [15:0] target;
    logic [15:0] spd_fs;
    logic [15:0] trq_fs;
    logic [15:0] on_dly;
    logic [15:0] off_dly;
  } srb_cfg_t;

  typedef struct packed {
    logic ramping;
    logic dyn_brake;
    logic drive_en;
    logic brake;
    logic at_speed;
    logic zero_speed;
  } srb_status_t;

  typedef struct packed {
    logic signed [15:0] spd_cmd;
    logic signed [15:0] spd_lim;
    logic signed [15:0] trq_cmd;
    logic signed [15:0] trq_lim;
  } srb_cmd_t;

endpackage : srb_pkg

/* srb_ctl.sv */
// Speed ramp, analog scaling, speed status flags and brake sequencing, APB slave.
// Assumes speed feedback and analog samples arrive from logic on sys_clk.
`timescale 1ns/1ns
`include "srb_cfg.svh"

// Behaviour
// - Stop mode 0 applies dynamic brake while the drive is disabled; 1 lets the motor coast.
// - Speed mode ramps command from zero to rated speed over accel time.
// - Speed mode ramps command from rated speed to zero over decel time.
// - S-curve time zero disables the ramp; accel and decel times ignored.
// - Nonzero S-curve rounds ramp ends; totals grow by the S-curve time.
// - Zero-speed flag high while speed at or below window, low above.
// - At-speed flag high when either-direction speed reaches target, low below.
// - Analog speed scaled as millivolts times full scale over ten volts.
// - Scaled speed is command in speed mode and limit in torque mode.
// - Analog torque scaled as millivolts times full scale over ten volts.
// - Scaled torque is command in torque mode, limit in position/speed.
// - Brake output activates the on-delay after servo-on.
// - Off-delay zero or positive: brake output drops that long after servo-off.
// - Negative off-delay: brake drops at once, drive disables after magnitude.
module srb_ctl #(
  parameter int TICK_CYCLES = `SRB_TICK_US * `SRB_CLK_MHZ,
  parameter logic [15:0] RATED_RPM = 16'h0BB8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] adc_speed_mv,
  input wire logic signed [15:0] adc_torque_mv,
  output logic zero_speed_flag,
  output logic at_speed_flag,
  output logic brake_release_output,
  output logic drive_enable,
  output logic dyn_brake,
  output srb_pkg::srb_cmd_t cmd,
  output logic irq
);

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  function automatic logic signed [15:0] scale(input logic signed [15:0] mv,
                                               input logic [15:0] fs);
    logic signed [32:0] p;
    p = mv * $signed({1'b0, fs});
    scale = 16'(p / 33'sd`SRB_FULL_MV);
  endfunction : scale

  function automatic logic [31:0] nz(input logic [15:0] t);
    nz = (t == 16'h0000) ? 32'h0000_0001 : {16'h0000, t};
  endfunction : nz

  function automatic logic mode_is(input srb_pkg::srb_ctrl_t c,
                                   input srb_pkg::srb_mode_t m);
    mode_is = (c.mode == m);
  endfunction : mode_is

  // APB slave and register file
  srb_pkg::srb_ctrl_t ctrl_q, ctrl_d;
  srb_pkg::srb_cfg_t cfg_q, cfg_d;
  logic [`SRB_IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [`SRB_IRQ_W-1:0] ev;
  srb_pkg::srb_status_t st_q, st_d;
  srb_pkg::srb_cmd_t cmd_q, cmd_d;
  logic irq_q, irq_d;
  logic [9:0] idx;
  logic hit, wr_now;
  logic acc_first;

  assign idx = paddr[11:2];
  assign wr_now = psel & penable & pready_q & pwrite;
  // First access cycle of a transfer
  assign acc_first = psel & penable & ~pready_q;

  always_comb begin
    hit = (paddr[1:0] == 2'h0);
    prdata_d = 32'h0000_0000;
    unique case (idx)
      `SRB_IDX_CTRL: prdata_d = {28'h0, ctrl_q};
      `SRB_IDX_STATUS: prdata_d = {26'h0, st_q};
      `SRB_IDX_IRQ_STAT: prdata_d = {28'h0, irq_stat_q};
      `SRB_IDX_IRQ_MASK: prdata_d = {28'h0, irq_mask_q};
      `SRB_IDX_SPD_CMD: prdata_d = {16'h0, cmd_q.spd_cmd};
      `SRB_IDX_TRQ_CMD: prdata_d = {16'h0, cmd_q.trq_cmd};
      `SRB_IDX_RSVD_A: prdata_d = 32'h0000_0000;
      `SRB_IDX_ACCEL: prdata_d = {16'h0, cfg_q.accel};
      `SRB_IDX_DECEL: prdata_d = {16'h0, cfg_q.decel};
      `SRB_IDX_SCURVE: prdata_d = {16'h0, cfg_q.scurve};
      `SRB_IDX_INERTIA: prdata_d = {16'h0, cfg_q.inertia};
      `SRB_IDX_ZERO_WIN: prdata_d = {16'h0, cfg_q.zero_win};
      `SRB_IDX_TARGET: prdata_d = {16'h0, cfg_q.target};
      `SRB_IDX_SPD_FS: prdata_d = {16'h0, cfg_q.spd_fs};
      `SRB_IDX_TRQ_FS: prdata_d = {16'h0, cfg_q.trq_fs};
      `SRB_IDX_ON_DLY: prdata_d = {16'h0, cfg_q.on_dly};
      `SRB_IDX_OFF_DLY: prdata_d = {16'h0, cfg_q.off_dly};
      default: hit = 1'b0;
    endcase
    if (!hit) begin
      prdata_d = 32'h0000_0000;
    end
    // One wait state: answer registered in the first access cycle
    pready_d = acc_first;
    pslverr_d = acc_first & ~hit;
    if (!acc_first || pwrite) begin
      prdata_d = 32'h0000_0000;
    end
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (wr_now && hit) begin
      unique case (idx)
        `SRB_IDX_CTRL: ctrl_d = pwdata[`SRB_CTRL_W-1:0];
        `SRB_IDX_IRQ_STAT: irq_stat_d = irq_stat_q & ~pwdata[`SRB_IRQ_W-1:0];
        `SRB_IDX_IRQ_MASK: irq_mask_d = pwdata[`SRB_IRQ_W-1:0];
        `SRB_IDX_ACCEL: cfg_d.accel = pwdata[15:0];
        `SRB_IDX_DECEL: cfg_d.decel = pwdata[15:0];
        `SRB_IDX_SCURVE: cfg_d.scurve = pwdata[15:0];
        `SRB_IDX_INERTIA: cfg_d.inertia = pwdata[15:0];
        `SRB_IDX_ZERO_WIN: cfg_d.zero_win = pwdata[15:0];
        `SRB_IDX_TARGET: cfg_d.target = pwdata[15:0];
        `SRB_IDX_SPD_FS: cfg_d.spd_fs = pwdata[15:0];
        `SRB_IDX_TRQ_FS: cfg_d.trq_fs = pwdata[15:0];
        `SRB_IDX_ON_DLY: cfg_d.on_dly = pwdata[15:0];
        `SRB_IDX_OFF_DLY: cfg_d.off_dly = pwdata[15:0];
        default: ;
      endcase
    end
    // Set wins over write-one-to-clear
    irq_stat_d = irq_stat_d | ev;
    irq_d = |(irq_stat_d & irq_mask_q);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= srb_pkg::srb_ctrl_t'(`SRB_CTRL_RST);
      // Settings leave reset at their defaults
      cfg_q.accel <= `SRB_ACCEL_RST;
      cfg_q.decel <= `SRB_DECEL_RST;
      cfg_q.scurve <= `SRB_SCURVE_RST;
      cfg_q.inertia <= `SRB_INERTIA_RST;
      cfg_q.zero_win <= `SRB_ZERO_WIN_RST;
      cfg_q.target <= `SRB_TARGET_RST;
      cfg_q.spd_fs <= RATED_RPM;
      cfg_q.trq_fs <= `SRB_TRQ_FS_RST;
      cfg_q.on_dly <= `SRB_ON_DLY_RST;
      cfg_q.off_dly <= `SRB_OFF_DLY_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // Millisecond tick
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;

  always_comb begin
    tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Servo-on and brake sequencing
  srb_pkg::srb_state_t seq_q, seq_d;
  logic [15:0] dly_q, dly_d;
  logic brake_q, brake_d, drv_q, drv_d;
  logic off_neg;
  logic [15:0] off_mag;

  always_comb begin
    off_neg = cfg_q.off_dly[15];
    off_mag = mag(cfg_q.off_dly);
    seq_d = seq_q;
    brake_d = brake_q;
    drv_d = drv_q;
    dly_d = dly_q;
    // Count saturates so a long stay cannot wrap below a delay setting
    if (tick && dly_q != 16'hFFFF) begin
      dly_d = dly_q + 16'h0001;
    end
    unique case (seq_q)
      srb_pkg::SRB_ST_OFF: begin
        if (ctrl_q.servo_on) begin
          seq_d = srb_pkg::SRB_ST_ONDLY;
          drv_d = 1'b1;
          dly_d = 16'h0000;
        end
      end
      srb_pkg::SRB_ST_ONDLY, srb_pkg::SRB_ST_RUN: begin
        if (!ctrl_q.servo_on) begin
          seq_d = srb_pkg::SRB_ST_OFFDLY;
          dly_d = 16'h0000;
          if (off_neg) begin
            brake_d = 1'b0;
          end else begin
            drv_d = 1'b0;
          end
        end else if (seq_q == srb_pkg::SRB_ST_ONDLY && dly_q >= cfg_q.on_dly) begin
          seq_d = srb_pkg::SRB_ST_RUN;
          brake_d = 1'b1;
        end
      end
      srb_pkg::SRB_ST_OFFDLY: begin
        if (ctrl_q.servo_on) begin
          seq_d = srb_pkg::SRB_ST_ONDLY;
          drv_d = 1'b1;
          dly_d = 16'h0000;
        end else if (dly_q >= off_mag) begin
          seq_d = srb_pkg::SRB_ST_OFF;
          brake_d = 1'b0;
          drv_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_q <= srb_pkg::SRB_ST_OFF;
      dly_q <= 16'h0000;
      brake_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      dly_q <= dly_d;
      brake_q <= brake_d;
      drv_q <= drv_d;
    end
  end

  // Speed ramp: linear stage then S-curve smoothing stage
  logic signed [15:0] lin_q, lin_d, sc_q, sc_d, tgt;
  logic [31:0] lpend_q, lpend_d, spend_q, spend_d, tsel;
  logic signed [15:0] a_spd, a_trq;
  logic accelerating;

  always_comb begin
    a_spd = scale(adc_speed_mv, cfg_q.spd_fs);
    a_trq = scale(adc_torque_mv, cfg_q.trq_fs);
    tgt = (drv_q && mode_is(ctrl_q, srb_pkg::SRB_MODE_SPD)) ? a_spd : 16'sh0000;
    accelerating = (tgt > lin_q && !lin_q[15]) || (tgt < lin_q && (lin_q[15] || lin_q == 0));
    tsel = accelerating ? nz(cfg_q.accel) : nz(cfg_q.decel);
    lin_d = lin_q;
    sc_d = sc_q;
    lpend_d = lpend_q;
    spend_d = spend_q;
    if (cfg_q.scurve == 16'h0000) begin
      lin_d = tgt;
      sc_d = tgt;
      lpend_d = 32'h0000_0000;
      spend_d = 32'h0000_0000;
    end else begin
      // Rated speed per setting time, spread as unit steps
      if (lin_q == tgt) begin
        lpend_d = 32'h0000_0000;
      end else begin
        if (tick) begin
          lpend_d = lpend_q + {16'h0000, RATED_RPM};
        end
        if (lpend_q >= tsel) begin
          lpend_d = lpend_d - tsel;
          lin_d = (tgt > lin_q) ? lin_q + 16'sh0001 : lin_q - 16'sh0001;
        end
      end
      // Lag of half the S-curve time rounds both ramp corners
      if (sc_q == lin_q) begin
        spend_d = 32'h0000_0000;
      end else begin
        if (tick) begin
          spend_d = spend_q + {15'h0000, mag(16'(lin_q - sc_q)), 1'b0};
        end
        if (spend_q >= {16'h0000, cfg_q.scurve}) begin
          spend_d = spend_d - {16'h0000, cfg_q.scurve};
          sc_d = (lin_q > sc_q) ? sc_q + 16'sh0001 : sc_q - 16'sh0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lin_q <= 16'sh0000;
      sc_q <= 16'sh0000;
      lpend_q <= 32'h0000_0000;
      spend_q <= 32'h0000_0000;
    end else begin
      lin_q <= lin_d;
      sc_q <= sc_d;
      lpend_q <= lpend_d;
      spend_q <= spend_d;
    end
  end

  // Commands, limits, status flags and events
  // Events held off for one clock after reset, as the flags leave reset low
  logic arm_q, arm_d;
  logic [15:0] spd_mag;

  always_comb begin
    arm_d = 1'b1;
    spd_mag = mag(motor_speed);
    cmd_d.spd_cmd = mode_is(ctrl_q, srb_pkg::SRB_MODE_SPD) ? sc_q : 16'sh0000;
    cmd_d.spd_lim = mode_is(ctrl_q, srb_pkg::SRB_MODE_TRQ) ? a_spd : 16'sh0000;
    cmd_d.trq_cmd = mode_is(ctrl_q, srb_pkg::SRB_MODE_TRQ) ? a_trq : 16'sh0000;
    cmd_d.trq_lim = !mode_is(ctrl_q, srb_pkg::SRB_MODE_TRQ) ? a_trq : 16'sh0000;
    st_d.zero_speed = (spd_mag <= cfg_q.zero_win);
    st_d.at_speed = (spd_mag >= cfg_q.target);
    st_d.brake = brake_q;
    st_d.drive_en = drv_q;
    st_d.dyn_brake = ~drv_q & ~ctrl_q.stop_coast;
    st_d.ramping = (sc_q != tgt);
    ev[0] = arm_q & st_d.zero_speed & ~st_q.zero_speed;
    ev[1] = arm_q & st_d.at_speed & ~st_q.at_speed;
    ev[2] = arm_q & (st_d.brake ^ st_q.brake);
    ev[3] = arm_q & ~st_d.drive_en & st_q.drive_en;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arm_q <= 1'b0;
      cmd_q <= '0;
      st_q <= '0;
    end else begin
      arm_q <= arm_d;
      cmd_q <= cmd_d;
      st_q <= st_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign cmd = cmd_q;
  assign zero_speed_flag = st_q.zero_speed;
  assign at_speed_flag = st_q.at_speed;
  assign brake_release_output = st_q.brake;
  assign drive_enable = st_q.drive_en;
  assign dyn_brake = st_q.dyn_brake;

endmodule : srb_ctl

/* srb_motor.sv */
// Motor model facing the drive outputs of the ramp, status and brake block.
// Assumes drive and command signals come from srb_ctl on sys_clk.
`timescale 1ns/1ns
module srb_motor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic drv,
  input wire logic dyn,
  input wire logic signed [15:0] cmd_rpm,
  output logic signed [15:0] rpm
);
  logic signed [15:0] tgt;
  assign tgt = drv ? cmd_rpm : 16'sh0;
  // One rpm per cycle toward target; coasting holds speed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rpm <= 16'sh0;
    end else if (drv || dyn) begin
      rpm <= rpm + ((rpm < tgt) ? 16'sh1 : (rpm > tgt) ? -16'sh1 : 16'sh0);
    end
  end
endmodule : srb_motor

/* srb_ctl_sva.sv */
// Checker of the ramp, status and brake block.
// Assumes it is bound to srb_ctl and sees only its ports.
`timescale 1ns/1ns
module srb_ctl_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [15:0] motor_speed,
  input wire logic zero_speed_flag,
  input wire logic brake_release_output,
  input wire logic drive_enable,
  input wire logic dyn_brake,
  input wire srb_pkg::srb_cmd_t cmd
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_one_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not quiet");
  a_dyn_off: assert property (dyn_brake |-> !drive_enable)
    else $error("dynamic brake while driving");
  a_brake_drive: assert property ($rose(brake_release_output) |-> drive_enable)
    else $error("brake output without drive");
  a_spd_excl: assert property (!(cmd.spd_cmd != 16'h0 && cmd.spd_lim != 16'h0))
    else $error("speed command and limit both set");
  a_trq_excl: assert property (cmd.trq_cmd != 16'h0 |-> cmd.trq_lim == 16'h0)
    else $error("torque command and limit both set");
  a_zero_flag: assert property (!$past(rst) && !$past(rst, 2) &&
    $past(motor_speed) == 16'sh0 |-> zero_speed_flag)
    else $error("zero speed flag low at rest");
endmodule : srb_ctl_sva
bind srb_ctl srb_ctl_sva u_srb_ctl_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .motor_speed(motor_speed), .zero_speed_flag(zero_speed_flag),
  .brake_release_output(brake_release_output), .drive_enable(drive_enable),
  .dyn_brake(dyn_brake), .cmd(cmd));

/* testbench.sv */
// Self-checking bench of the ramp, status and brake block.
// Assumes srb_pkg, srb_ctl, srb_motor and the checker are compiled first.
`timescale 1ns/1ns
module testbench;
  localparam int TK = 1200;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic zf, af, brk, drv, dyn, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic signed [15:0] spd, adc_s, adc_t;
  srb_pkg::srb_cmd_t cmd;
  int num_errors, compares, i, j;
  srb_ctl #(.TICK_CYCLES(TK), .RATED_RPM(16'h03E8)) u_srb_ctl (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_speed(spd), .adc_speed_mv(adc_s), .adc_torque_mv(adc_t),
    .zero_speed_flag(zf), .at_speed_flag(af), .brake_release_output(brk),
    .drive_enable(drv), .dyn_brake(dyn), .cmd(cmd), .irq(irq));
  srb_motor u_srb_motor (.sys_clk(sys_clk), .rst(rst), .drv(drv), .dyn(dyn),
    .cmd_rpm(cmd.spd_cmd), .rpm(spd));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic int sc(input int mv, input int fs);
    return mv * fs / 32'sh2710;
  endfunction : sc
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wrap_up;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task apb(input logic w, input logic [9:0] ix, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'h1;
    while (pready !== 1'h1) @(posedge sys_clk);
    rv = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb
  task wr(input logic [9:0] ix, input logic [31:0] d);
    apb(1'h1, ix, d);
  endtask : wr
  // Bounded wait: 0 brake, 1 drive, 2 speed command, 3 motor speed
  task wt(input int s, input logic [15:0] v, input int n);
    for (j = 0; j < n && (s == 0 ? {15'h0, brk} : s == 1 ? {15'h0, drv} :
      s == 2 ? cmd.spd_cmd : spd) !== v; j++) @(posedge sys_clk);
  endtask : wt
  task t_regs;
    logic [9:0] ix [6] = '{10'h122, 10'h123, 10'h124, 10'h129, 10'h12B, 10'h121};
    logic [15:0] ev [6] = '{16'hC8, 16'hC8, 16'h0, 16'h64, 16'h64, 16'h0};
    for (i = 0; i < 6; i++) begin
      apb(1'h0, ix[i], 32'h0);
      chk("reset", rv, {16'h0, ev[i]});
    end
    wr(10'h121, 32'h1234);
    apb(1'h0, 10'h121, 32'h0);
    chk("rsvd", {rv[30:0], er}, 32'h0);
    apb(1'h0, 10'h3FF, 32'h0);
    chk("unmapped", er, 1'h1);
    apb(1'h0, 10'h101, 32'h0);
    chk("status", rv, 32'h11);
    apb(1'h0, 10'h102, 32'h0);
    chk("stat_rst", rv, 32'h0);
  endtask : t_regs
  task t_scale;
    adc_s <= 16'h1388;
    adc_t <= 16'hEC78;
    wr(10'h100, 32'h4);
    cyc(4);
    chk("spd_lim", cmd.spd_lim, sc(32'sh1388, 32'sh3E8));
    chk("trq_cmd", cmd.trq_cmd, sc(-32'sh1388, 32'sh64));
    chk("trq_lim", cmd.trq_lim, 32'h0);
    wr(10'h129, 32'h12C);
    adc_t <= 16'h2710;
    wr(10'h100, 32'h0);
    cyc(4);
    chk("trq_lim", cmd.trq_lim, sc(32'sh2710, 32'sh12C));
    chk("spd_lim", cmd.spd_lim, 32'h0);
  endtask : t_scale
  task t_speed;
    wr(10'h100, 32'h3);
    wt(3, 16'h1F4, 3000);
    chk("spd_cmd", cmd.spd_cmd, sc(32'sh1388, 32'sh3E8));
    chk("trq_lim", cmd.trq_lim, 32'h12C);
    wr(10'h127, 32'h1F4);
    wr(10'h126, 32'h1F3);
    cyc(3);
    chk("at", af, 1'h1);
    chk("zero", zf, 1'h0);
    wr(10'h126, 32'h1F4);
    cyc(3);
    chk("zero", zf, 1'h1);
    wr(10'h127, 32'h1F5);
    cyc(3);
    chk("at", af, 1'h0);
    wr(10'h126, 32'hA);
    wr(10'h127, 32'h1F4);
    adc_s <= 16'hEC78;
    wt(3, 16'hFE0C, 3000);
    cyc(3);
    chk("at", af, 1'h1);
    chk("zero", zf, 1'h0);
  endtask : t_speed
  task t_ramp;
    adc_s <= 16'h0;
    cyc(4);
    chk("spd_cmd", cmd.spd_cmd, 32'h0);
    wr(10'h124, 32'h2);
    wr(10'h122, 32'h2);
    wr(10'h123, 32'h2);
    adc_s <= 16'h1388;
    cyc(20);
    chk("ramp", cmd.spd_cmd < 16'sh1F4, 1'h1);
    wt(2, 16'h1F4, 20 * TK);
    chk("spd_cmd", cmd.spd_cmd, 32'h1F4);
    adc_s <= 16'h0;
    cyc(20);
    chk("ramp", cmd.spd_cmd > 16'sh0, 1'h1);
    wt(2, 16'h0, 20 * TK);
    chk("spd_cmd", cmd.spd_cmd, 32'h0);
  endtask : t_ramp
  task t_brake;
    wr(10'h100, 32'h0);
    wr(10'h12A, 32'h2);
    wr(10'h12B, 32'h2);
    wt(0, 16'h0, 3 * TK);
    chk("brk", brk, 1'h0);
    wr(10'h102, 32'hF);
    wr(10'h100, 32'h1);
    wt(1, 16'h1, 10);
    cyc(TK - 100);
    chk("brk", brk, 1'h0);
    wt(0, 16'h1, TK + 200);
    chk("brk", brk, 1'h1);
    wr(10'h100, 32'h0);
    wt(1, 16'h0, 10);
    chk("dyn", dyn, 1'h1);
    chk("brk", brk, 1'h1);
    wt(0, 16'h0, 2 * TK + 100);
    chk("brk", brk, 1'h0);
    chk("irq", irq, 1'h0);
    apb(1'h0, 10'h102, 32'h0);
    chk("stat", rv & 32'hC, 32'hC);
    wr(10'h103, 32'hC);
    cyc(2);
    chk("irq", irq, 1'h1);
    wr(10'h102, 32'hC);
    cyc(2);
    chk("irq", irq, 1'h0);
    wr(10'h12B, 32'hFFFE);
    wr(10'h100, 32'h9);
    wt(0, 16'h1, 3 * TK);
    wr(10'h100, 32'h8);
    wt(0, 16'h0, 10);
    chk("brk", brk, 1'h0);
    cyc(TK - 100);
    chk("drv", drv, 1'h1);
    chk("dyn", dyn, 1'h0);
    wt(1, 16'h0, TK + 200);
    cyc(2);
    chk("drv", drv, 1'h0);
    chk("dyn", dyn, 1'h0);
  endtask : t_brake
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    adc_s = '0;
    adc_t = '0;
    num_errors = 0;
    compares = 0;
    cyc(16);
    rst <= 1'h0;
    cyc(1);
    t_regs;
    t_scale;
    t_speed;
    t_ramp;
    t_brake;
    wrap_up;
  end
  initial begin
    #800000;
    num_errors++;
    wrap_up;
  end
endmodule : testbench
